// [src/flash_host_pkg.sv]
// constants of the flash command host controller
package flash_host_pkg;
  // command codes (low data byte)
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONF   = 8'hD0;
  localparam logic [7:0] CMD_ERASE_SUSP   = 8'hB0;
  // status byte bit positions
  localparam int BIT_READY   = 7;
  localparam int BIT_PAUSED  = 6;
  localparam int BIT_EFAIL   = 5;
  localparam int BIT_PFAIL   = 4;
  localparam int BIT_VLOW    = 3;
  localparam logic [7:0] STATUS_MASK = 8'hF8;
  // own registers, byte offsets on the bus
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_OPCODE = 8'h14;
  // operations written to control bits [3:0]
  localparam logic [3:0] OP_READ_ARRAY = 4'h0;
  localparam logic [3:0] OP_READ_ID    = 4'h1;
  localparam logic [3:0] OP_READ_STAT  = 4'h2;
  localparam logic [3:0] OP_CLEAR      = 4'h3;
  localparam logic [3:0] OP_PROGRAM    = 4'h4;
  localparam logic [3:0] OP_ERASE      = 4'h5;
  localparam logic [3:0] OP_SUSPEND    = 4'h6;
  localparam logic [3:0] OP_RESUME     = 4'h7;
  localparam logic [3:0] OP_RAW_WRITE  = 4'h8;
  // pin timing at a 20 ns clock; the strobe gets two extra cycles for the input synchroniser
  localparam int CLK_NS       = 20;
  localparam int STROBE_NS    = 80;
  localparam int SETUP_NS     = 40;
  localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_W       = 20;
  localparam int DATA_W       = 16;
endpackage

// [src/flash_pin_if.sv]
// interface carrying one pin cycle request between sequencer and pin driver
`timescale 1ns/1ns
`default_nettype none
interface flash_pin_if;
  logic        req;
  logic        wr;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport drv (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// [src/flash_pin_cycle.sv]
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
module flash_pin_cycle
  import flash_host_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  flash_pin_if.drv         pc,
  input  wire logic [15:0] dq_in,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic [19:0]      addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe
);
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} pstate_e;
  typedef struct packed {
    pstate_e     st;
    logic [3:0]  cnt;
    logic        wr;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [19:0] addr;
    logic [15:0] dout;
    logic        doe;
    logic        done;
    logic [15:0] rdata;
    logic [15:0] s1;
    logic [15:0] s2;
  } pin_s;
  pin_s q_r, q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    q_nxt.s1 = dq_in;
    q_nxt.s2 = q_r.s1;
    case (q_r.st)
      P_IDLE:
        if (pc.req)
        begin
          q_nxt.st = P_SETUP;
          q_nxt.wr = pc.wr;
          q_nxt.addr = pc.addr;
          q_nxt.dout = pc.wdata;
          q_nxt.doe = pc.wr;
          q_nxt.ce_n = 1'b0;
          q_nxt.cnt = 4'(SETUP_CYC);
        end
      P_SETUP:
        if (q_r.cnt <= 4'd1)
        begin
          q_nxt.st = P_STROBE;
          q_nxt.we_n = ~q_r.wr;
          q_nxt.oe_n = q_r.wr;
          q_nxt.cnt = 4'(STROBE_CYC + 2);
        end
        else
          q_nxt.cnt = q_r.cnt - 4'd1;
      P_STROBE:
        if (q_r.cnt <= 4'd1)
        begin
          // the command latches on the rising write strobe while chip enable stays low
          q_nxt.st = P_HOLD; // R20
          q_nxt.we_n = 1'b1;
          q_nxt.oe_n = 1'b1;
          q_nxt.rdata = q_r.s2;
          q_nxt.cnt = 4'(SETUP_CYC);
        end
        else
          q_nxt.cnt = q_r.cnt - 4'd1;
      P_HOLD:
        if (q_r.cnt <= 4'd1)
        begin
          q_nxt.st = P_IDLE;
          q_nxt.ce_n = 1'b1;
          q_nxt.doe = 1'b0;
          q_nxt.done = 1'b1;
        end
        else
          q_nxt.cnt = q_r.cnt - 4'd1;
      default:
        q_nxt.st = P_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q_r <= '0;
      q_r.ce_n <= 1'b1;
      q_r.we_n <= 1'b1;
      q_r.oe_n <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  assign pc.done = q_r.done;
  assign pc.rdata = q_r.rdata;
  assign ce_n = q_r.ce_n;
  assign we_n = q_r.we_n;
  assign oe_n = q_r.oe_n;
  assign addr = q_r.addr;
  assign dq_out = q_r.dout;
  assign dq_oe = q_r.doe;
endmodule
`default_nettype wire

// [src/flash_cmd_host.sv]
// host controller issuing flash command sequences from ahb-lite registers
// Overview of operation
// R1: identifier read: write 90h, then read with address bit 0 choosing maker or part
// R2: after 70h every read yields the status byte, any address
// R3: program setup code 40h or 10h; both accepted alike
// R4: program is setup code, then write of value at target location
// R5: erase is 20h then D0h, both at an address inside the block
// R6: commands sit in the low data byte; upper byte is ignored
// R7: bit 7 ready; wait for it before reading error bits
// R8: erase suspend makes the device ready with bit 6 set
// R9: bit 6 holds until erase resume; reads 0 while erasing
// R10: bit 5 means erase failed or voltage out of range
// R11: bit 4 means program failed or voltage out of range
// R12: a non-confirm after erase setup sets bits 5 and 4
// R13: bit 3 reports low voltage, sampled only at operation start
// R14: host masks reserved status bits 2 to 0
// R15: error bits stick until the clear-status command
// R16: device returns to status-read mode after program or erase
// R17: during erase only status-read and suspend are accepted
// R18: while suspended only read array, status-read and resume accepted
// R19: ffh at any address returns to array read
// R20: command captured on rising edge of the first strobe to rise
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host
  import flash_host_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic [19:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in
);
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_SECOND, S_POLL, S_DONE} seq_e;
  typedef struct packed {
    seq_e        st;
    logic [3:0]  op;
    logic        busy;
    logic        poll_en;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [7:0]  status;
    logic        op_err;
    logic        pend;
    logic [7:0]  aofs;
    logic        awr;
    logic [31:0] hrdata;
    logic        req;
    logic        wr;
    logic [19:0] paddr;
    logic [15:0] pdata;
  } host_s;
  host_s q_r, q_nxt;
  flash_pin_if pc();

  flash_pin_cycle u_pin (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pc      (pc),
    .dq_in   (flash_dq_in),
    .ce_n    (flash_ce_n),
    .we_n    (flash_we_n),
    .oe_n    (flash_oe_n),
    .addr    (flash_addr),
    .dq_out  (flash_dq_out),
    .dq_oe   (flash_dq_oe)
  );
  assign pc.req = q_r.req;
  assign pc.wr = q_r.wr;
  assign pc.addr = q_r.paddr;
  assign pc.wdata = q_r.pdata;

  function automatic logic [7:0] first_code(input logic [3:0] op);
    case (op)
      OP_READ_ID:   first_code = CMD_READ_ID; // R1
      OP_READ_STAT: first_code = CMD_READ_STATUS; // R2
      OP_CLEAR:     first_code = CMD_CLEAR_STATUS; // R15
      OP_PROGRAM:   first_code = CMD_PROG_SETUP; // R3
      OP_ERASE:     first_code = CMD_ERASE_SETUP; // R5
      OP_SUSPEND:   first_code = CMD_ERASE_SUSP; // R8
      OP_RESUME:    first_code = CMD_ERASE_CONF; // R9
      default:      first_code = CMD_READ_ARRAY; // R19
    endcase
  endfunction

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.req = 1'b0;
    // data phase of the previous address phase
    if (q_r.pend && q_r.awr)
    begin
      case (q_r.aofs)
        OFS_CTRL:
          if (!q_r.busy)
          begin
            q_nxt.op = hwdata[3:0];
            q_nxt.poll_en = hwdata[4];
            q_nxt.busy = 1'b1;
            q_nxt.op_err = 1'b0;
            q_nxt.st = S_CMD;
          end
        OFS_ADDR:  q_nxt.addr = hwdata[19:0];
        OFS_WDATA: q_nxt.wdata = hwdata[15:0];
        default:   ;
      endcase
    end
    q_nxt.pend = hsel && hready && htrans[1];
    q_nxt.aofs = haddr[7:0];
    q_nxt.awr = hwrite;
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        OFS_CTRL:   q_nxt.hrdata = {27'h0, q_r.poll_en, q_r.op};
        OFS_ADDR:   q_nxt.hrdata = {12'h000, q_r.addr};
        OFS_WDATA:  q_nxt.hrdata = {16'h0000, q_r.wdata};
        OFS_RDATA:  q_nxt.hrdata = {16'h0000, q_r.rdata};
        OFS_STAT:   q_nxt.hrdata = {22'h0, q_r.op_err, q_r.busy, q_r.status};
        OFS_OPCODE: q_nxt.hrdata = {24'h0, first_code(q_r.op)};
        default:    q_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    case (q_r.st)
      S_IDLE: ;
      S_CMD:
        if (!q_r.req && !pc.done)
        begin
          q_nxt.req = 1'b1;
          q_nxt.wr = 1'b1;
          q_nxt.paddr = q_r.addr; // R5
          // upper byte driven low except for OP_RAW_WRITE, which sends wdata whole; the device decodes only the low byte
          q_nxt.pdata = {8'h00, first_code(q_r.op)}; // R6
          if (q_r.op == OP_RAW_WRITE)
            q_nxt.pdata = q_r.wdata;
          q_nxt.st = S_SECOND;
        end
      S_SECOND:
        if (pc.done)
        begin
          case (q_r.op)
            OP_READ_ID, OP_READ_ARRAY:
            begin
              q_nxt.req = 1'b1;
              q_nxt.wr = 1'b0;
              q_nxt.paddr = q_r.addr; // R1
              q_nxt.st = S_DONE;
            end
            OP_READ_STAT:
            begin
              q_nxt.req = 1'b1;
              q_nxt.wr = 1'b0;
              q_nxt.st = S_DONE; // R2
            end
            OP_PROGRAM:
            begin
              q_nxt.req = 1'b1;
              q_nxt.wr = 1'b1;
              q_nxt.pdata = q_r.wdata; // R4
              // stay busy until the pin cycle ends, or the next op's request is lost
              q_nxt.st = q_r.poll_en ? S_POLL : S_DONE;
            end
            OP_ERASE:
            begin
              q_nxt.req = 1'b1;
              q_nxt.wr = 1'b1;
              q_nxt.pdata = {8'h00, CMD_ERASE_CONF}; // R5
              q_nxt.st = q_r.poll_en ? S_POLL : S_DONE;
            end
            default:
            begin
              q_nxt.st = S_IDLE;
              q_nxt.busy = 1'b0;
            end
          endcase
        end
      S_POLL:
        // device is in status-read mode after the operation; keep reading
        if (pc.done)
        begin
          q_nxt.req = 1'b1; // R16 R17
          q_nxt.wr = 1'b0;
          q_nxt.op = OP_READ_STAT;
          q_nxt.st = S_DONE;
        end
      S_DONE:
        if (pc.done)
        begin
          // a write cycle only echoes our own data; keep the last read value
          if (!q_r.wr)
            q_nxt.rdata = pc.rdata;
          if (q_r.op == OP_READ_STAT)
          begin
            q_nxt.status = pc.rdata[7:0] & STATUS_MASK; // R14
            if (q_r.poll_en && !pc.rdata[BIT_READY])
            begin
              q_nxt.req = 1'b1; // R7
              q_nxt.wr = 1'b0;
            end
            else
            begin
              q_nxt.st = S_IDLE;
              q_nxt.busy = 1'b0;
              // error bits judged only once ready; they stick until cleared
              q_nxt.op_err = pc.rdata[BIT_READY] && !pc.rdata[BIT_PAUSED] &&
                (pc.rdata[BIT_EFAIL] || pc.rdata[BIT_PFAIL] ||
                 pc.rdata[BIT_VLOW]); // R7 R10 R11 R12 R13 R18
            end
          end
          else
          begin
            q_nxt.st = S_IDLE;
            q_nxt.busy = 1'b0;
          end
        end
      default:
        q_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = q_r.hrdata;
endmodule
`default_nettype wire

// [tb/flash_cmd_host_asserts.sv]
// concurrent checks on the flash host pin ports
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host_asserts
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_we_low;
    !flash_we_n [*3];
  endsequence
  sequence s_oe_low;
    !flash_oe_n [*3];
  endsequence
  a_we_pulse: assert property ($fell(flash_we_n) |-> s_we_low ##[1:12] flash_we_n)
    else $error("write strobe length wrong");
  a_oe_pulse: assert property ($fell(flash_oe_n) |-> s_oe_low ##[1:12] flash_oe_n)
    else $error("read strobe length wrong");
  a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
    else $error("write strobe outside select");
  a_rd_no_drive: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
    else $error("data driven during read");
  a_wr_setup: assert property ($fell(flash_we_n) |-> $past(flash_ce_n, 2) == 1'b0)
    else $error("select setup too short");
  a_wr_hold: assert property ($rose(flash_we_n) |-> !flash_ce_n && flash_dq_oe
    && $stable(flash_addr) && $stable(flash_dq_out))
    else $error("no hold after capture edge");
  a_wr_steady: assert property (!flash_we_n |=> flash_we_n
    || ($stable(flash_addr) && $stable(flash_dq_out)))
    else $error("address or data moved in strobe");
  a_ce_release: assert property ($rose(flash_ce_n) |-> flash_we_n && flash_oe_n
    && !flash_dq_oe)
    else $error("select released too early");
endmodule
`default_nettype wire

// [tb/flash_dev_model.sv]
// behavioural flash device answering the host pin cycles
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model
#(
  parameter logic [15:0] MK      = 16'h00A5,
  parameter logic [15:0] PT      = 16'h005A,
  parameter int          BUSY_NS = 3000
)
(
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq_in,
  input  wire logic        vpp_low,
  input  wire logic        fail_next,
  output logic      [15:0] dq_out
);
  logic [15:0] mem [0:1048575];
  logic [7:0]  sr = 8'h80;
  logic [1:0]  mode = 2'd0;
  logic        pp = 1'b0;
  logic        ep = 1'b0;
  logic        er = 1'b0;
  logic [19:0] ea;
  logic [15:0] pd;
  logic [15:0] last = 16'h0;
  int          gen = 0;
  wire         wstb = !ce_n && !we_n;
  wire  [7:0]  c = dq_in[7:0];
  // reserved bits carry junk on purpose
  wire  [15:0] rv = mode == 2'd2 ? {8'h00, sr[7:3], gen[2:0]} :
    mode == 2'd1 ? (addr[0] ? PT : MK) : mem[addr];
  // a released bus shows the inverse of the last value, never a held copy
  assign dq_out = (!ce_n && !oe_n) ? rv : ~last;
  initial
    foreach (mem[i]) mem[i] = 16'hFFFF;
  always @(posedge oe_n)
    last = rv;
  task automatic run(input logic e);
    int g;
    g = ++gen;
    sr[7] = 1'b0;
    #BUSY_NS;
    if (g == gen)
    begin
      sr[7] = 1'b1;
      er = 1'b0;
      if (fail_next)
        sr[e ? 5 : 4] = 1'b1;
      else if (e)
        for (int i = 0; i < 4096; i++) mem[{ea[19:12], i[11:0]}] = 16'hFFFF;
      else
        mem[ea] = pd;
    end
  endtask
  task automatic start(input logic e);
    mode = 2'd2;
    ea = addr;
    pd = dq_in;
    if (vpp_low)
      sr = sr | (e ? 8'h28 : 8'h18);
    else
    begin
      er = e;
      fork
        run(e);
      join_none
    end
  endtask
  // capture at whichever strobe rises first
  always @(negedge wstb)
  begin
    if (pp)
    begin
      pp = 1'b0;
      start(1'b0);
    end
    else if (ep)
    begin
      ep = 1'b0;
      if (c == 8'hD0)
        start(1'b1);
      else
      begin
        sr = sr | 8'h30;
        mode = 2'd2;
      end
    end
    else if (er && !sr[7])
    begin
      if (c == 8'h70)
        mode = 2'd2;
      if (c == 8'hB0)
      begin
        gen++;
        sr[7:6] = 2'b11;
      end
    end
    else if (er)
    begin
      if (c == 8'hFF)
        mode = 2'd0;
      if (c == 8'h70)
        mode = 2'd2;
      if (c == 8'hD0)
      begin
        sr[6] = 1'b0;
        fork
          run(1'b1);
        join_none
      end
    end
    else
      case (c)
        8'hFF: mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70: mode = 2'd2;
        8'h50: sr[5:3] = 3'h0;
        8'h40, 8'h10: pp = 1'b1;
        8'h20: ep = 1'b1;
        default: ;
      endcase
  end
endmodule
`default_nettype wire

// [tb/flash_cmd_host_tb_top.sv]
// testbench top of the flash host with a device model
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host_tb_top import flash_host_pkg::*;;
  localparam logic [15:0] MK = 16'h00A5; // arbitrary code
  localparam logic [15:0] PT = 16'h005A; // arbitrary code
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, vpp_low = 0, fail_next = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [19:0] a = 0, p;
  logic [15:0] d = 0, v;
  wire         hready, hresp, ce_n, we_n, oe_n, dq_oe;
  wire  [19:0] fa;
  wire  [15:0] dq_o, dev_q, dq;
  int          num_errors = 0, compares = 0;
  always #10 hclk = ~hclk;
  assign dq = dq_oe ? dq_o : dev_q;
  flash_cmd_host DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata, .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_addr(fa), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq));
  flash_dev_model #(.MK(MK), .PT(PT)) DEV (.ce_n, .we_n, .oe_n, .addr(fa), .dq_in(dq),
    .vpp_low, .fail_next, .dq_out(dev_q));
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic op(input logic [3:0] o, input logic pe);
    bus(1'b1, OFS_ADDR, {12'h0, a});
    bus(1'b1, OFS_WDATA, {16'h0, d});
    bus(1'b1, OFS_CTRL, {27'h0, pe, o});
    do bus(1'b0, OFS_STAT, 32'h0); while (rd[8] !== 1'b0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] sx(input logic [7:0] s, input logic e);
    return {22'h0, e, 1'b0, s & STATUS_MASK};
  endfunction
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    stop_test;
  end
  initial
  begin
    void'($urandom(27732));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      a = (20'($urandom) & 20'hFFFFE) | 20'(i);
      op(OP_READ_ID, 1'b0);
      bus(1'b0, OFS_RDATA, 32'h0);
      chk(rd, {16'h0, i ? PT : MK});
      bus(1'b0, OFS_OPCODE, 32'h0);
      chk(rd, {24'h0, CMD_READ_ID});
    end
    $display("test ident done");
    for (int i = 0; i < 4; i++)
    begin
      a = 20'($urandom);
      v = 16'($urandom);
      d = v;
      if (i[0])
      begin
        d = {8'($urandom), CMD_PROG_ALT}; // junk upper byte must not matter
        op(OP_RAW_WRITE, 1'b0);
        d = v;
        op(OP_RAW_WRITE, 1'b0);
        do op(OP_READ_STAT, 1'b0); while (rd[7] !== 1'b1);
      end
      else
        op(OP_PROGRAM, 1'b1);
      chk(rd, sx(8'h80, 1'b0));
      op(OP_READ_ARRAY, 1'b0);
      bus(1'b0, OFS_RDATA, 32'h0);
      chk(rd, {16'h0, v});
    end
    p = a;
    a = {p[19:12], 12'($urandom)};
    op(OP_ERASE, 1'b1);
    a = p;
    op(OP_READ_ARRAY, 1'b0);
    bus(1'b0, OFS_RDATA, 32'h0);
    chk(rd, 32'h0000FFFF);
    $display("test program erase done");
    op(OP_ERASE, 1'b0);
    op(OP_SUSPEND, 1'b0);
    op(OP_READ_STAT, 1'b0);
    chk(rd, sx(8'hC0, 1'b0));
    op(OP_READ_ID, 1'b0);
    bus(1'b0, OFS_RDATA, 32'h0);
    chk(rd & 32'hF8, 32'hC0);
    op(OP_RESUME, 1'b0);
    op(OP_READ_ARRAY, 1'b0);
    bus(1'b0, OFS_RDATA, 32'h0);
    chk(rd & 32'hF8, 32'h00);
    do op(OP_READ_STAT, 1'b0); while (rd[7] !== 1'b1);
    $display("test suspend done");
    d = {8'h00, CMD_ERASE_SETUP};
    op(OP_RAW_WRITE, 1'b0);
    d = {8'h00, CMD_READ_ARRAY};
    op(OP_RAW_WRITE, 1'b0);
    op(OP_READ_STAT, 1'b0);
    chk(rd, sx(8'hB0, 1'b1));
    op(OP_PROGRAM, 1'b1);
    chk(rd, sx(8'hB0, 1'b1));
    for (int k = 0; k < 5; k++)
    begin
      op(OP_CLEAR, 1'b0);
      op(OP_READ_STAT, 1'b0);
      chk(rd, sx(8'h80, 1'b0));
      if (k == 4)
        break;
      vpp_low <= (k < 2);
      fail_next <= (k >= 2);
      op(k[0] ? OP_ERASE : OP_PROGRAM, 1'b1);
      chk(rd, sx(8'h80 | (k[0] ? 8'h20 : 8'h10) | (k < 2 ? 8'h08 : 8'h00), 1'b1));
      vpp_low <= 1'b0;
      fail_next <= 1'b0;
    end
    $display("test errors done");
    stop_test;
  end
endmodule
bind flash_cmd_host flash_cmd_host_asserts CHK (.hclk, .hresetn, .flash_ce_n, .flash_we_n,
  .flash_oe_n, .flash_addr, .flash_dq_out, .flash_dq_oe);
`default_nettype wire
